// ===== hw/lprs_consts.vh
// Constants for the low-power recalibration scheduler
`ifndef LPRS_CONSTS_VH
`define LPRS_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define LPRS_ADDR_W        9
`define LPRS_OFF_LP_CTRL   9'h06E
`define LPRS_OFF_GAIN      9'h07A
`define LPRS_OFF_REFV      9'h07C
`define LPRS_OFF_TERM_A    9'h07E
`define LPRS_OFF_TRIG_CFG  9'h06B
`define LPRS_OFF_SOFT_TRIG 9'h06C
`define LPRS_OFF_STATUS    9'h0F0

// ****************************************
// Reset values and fields
// ****************************************
`define LPRS_LP_CTRL_RST   8'h88
`define LPRS_SOFT_TRIG_RST 1'h1
`define LPRS_REFV_MASK     8'h0F
`define LPRS_IDLE_MSB      7
`define LPRS_IDLE_LSB      5
`define LPRS_SETTLE_MSB    4
`define LPRS_SETTLE_LSB    3
`define LPRS_RSVD_BIT      2
`define LPRS_PACE_BIT      1
`define LPRS_ON_BIT        0

// ****************************************
// Interval lengths in sample clock periods
// ****************************************
`define LPRS_CNT_W   41
`define LPRS_T_1152  41'h000_0000_0480
`define LPRS_T_4M    41'h000_0040_0080
`define LPRS_T_33M   41'h000_0200_0080
`define LPRS_T_268M  41'h000_1000_0080
`define LPRS_T_2G    41'h000_8000_0080
`define LPRS_T_17G   41'h004_0000_0080
`define LPRS_T_137G  41'h020_0000_0080
`define LPRS_T_1T    41'h100_0000_0080
`define LPRS_CNT_ONE 41'h000_0000_0001
`define LPRS_CNT_ZERO 41'h000_0000_0000

// ****************************************
// Scheduler states
// ****************************************
`define LPRS_ST_OFF    2'h0
`define LPRS_ST_SLEEP  2'h1
`define LPRS_ST_SETTLE 2'h2
`define LPRS_ST_CAL    2'h3

`endif

// ===== hw/lprs_top.v
// Low-power recalibration scheduler with fuse-loaded trim registers
`timescale 1ns/10ps
`include "lprs_consts.vh"

module lprs_top #(
  parameter CNT_W = `LPRS_CNT_W
) (
  input  wire                     clk_i,
  input  wire                     resetn_i,
  input  wire [`LPRS_ADDR_W-1:0]  addr_i,
  input  wire [7:0]               wdata_i,
  input  wire                     wr_i,
  input  wire                     rd_i,
  output reg  [7:0]               rdata_o,
  input  wire                     background_recal_on_i,
  input  wire                     recal_trigger_input_i,
  input  wire [7:0]               fuse_gain_i,
  input  wire [3:0]               fuse_refv_i,
  input  wire [7:0]               fuse_term_a_i,
  input  wire                     cal_done_i,
  output reg                      core_sleep_o,
  output reg                      cal_start_o,
  output wire [7:0]               core_gain_adjust_o,
  output wire [3:0]               reference_voltage_adjust_o,
  output wire [7:0]               input_termination_adjust_a_o
);

  // ****************************************
  // Reset synchroniser
  // ****************************************
  reg rst_meta_r;
  reg rst_sync_r;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire rstn = rst_sync_r;

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] lp_ctrl_r;
  reg [7:0] gain_r;
  reg [3:0] refv_r;
  reg [7:0] term_a_r;
  reg       trig_src_r;
  reg       soft_trig_r;
  reg       fuse_load_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] cnt_nxt;

  wire wr_ctrl   = wr_i && (addr_i == `LPRS_OFF_LP_CTRL);
  wire wr_gain   = wr_i && (addr_i == `LPRS_OFF_GAIN);
  wire wr_refv   = wr_i && (addr_i == `LPRS_OFF_REFV);
  wire wr_term_a = wr_i && (addr_i == `LPRS_OFF_TERM_A);
  wire wr_tcfg   = wr_i && (addr_i == `LPRS_OFF_TRIG_CFG);
  wire wr_soft   = wr_i && (addr_i == `LPRS_OFF_SOFT_TRIG);

  // Control and trigger configuration
  always @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      lp_ctrl_r   <= `LPRS_LP_CTRL_RST;
      trig_src_r  <= 1'b0;
      soft_trig_r <= `LPRS_SOFT_TRIG_RST;
    end else begin
      if (wr_ctrl) begin
        lp_ctrl_r <= wdata_i;
      end
      if (wr_tcfg) begin
        trig_src_r <= wdata_i[0];
      end
      if (wr_soft) begin
        soft_trig_r <= wdata_i[0];
      end
    end
  end

  // Trim registers, loaded from fuses on the first cycle after reset release
  always @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      fuse_load_r <= 1'b1;
      gain_r      <= 8'h00;
      refv_r      <= 4'h0;
      term_a_r    <= 8'h00;
    end else begin
      fuse_load_r <= 1'b0;
      if (fuse_load_r) begin
        gain_r   <= fuse_gain_i;
        refv_r   <= fuse_refv_i;
        term_a_r <= fuse_term_a_i;
      end else begin
        if (wr_gain) begin
          gain_r <= wdata_i;
        end
        if (wr_refv) begin
          refv_r <= wdata_i[3:0];
        end
        if (wr_term_a) begin
          term_a_r <= wdata_i;
        end
      end
    end
  end

  assign core_gain_adjust_o           = gain_r;
  assign reference_voltage_adjust_o   = refv_r;
  assign input_termination_adjust_a_o = term_a_r;

  // ****************************************
  // Read port
  // ****************************************
  always @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `LPRS_OFF_LP_CTRL:   rdata_o <= lp_ctrl_r;
        `LPRS_OFF_GAIN:      rdata_o <= gain_r;
        `LPRS_OFF_REFV:      rdata_o <= {4'h0, refv_r} & `LPRS_REFV_MASK;
        `LPRS_OFF_TERM_A:    rdata_o <= term_a_r;
        `LPRS_OFF_TRIG_CFG:  rdata_o <= {7'h00, trig_src_r};
        `LPRS_OFF_SOFT_TRIG: rdata_o <= {7'h00, soft_trig_r};
        `LPRS_OFF_STATUS:    rdata_o <= {6'h00, state_r};
        default:             rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ****************************************
  // Interval decode
  // ****************************************
  wire [2:0] idle_interval_sel   = lp_ctrl_r[`LPRS_IDLE_MSB:`LPRS_IDLE_LSB];
  wire [1:0] settle_interval_sel = lp_ctrl_r[`LPRS_SETTLE_MSB:`LPRS_SETTLE_LSB];
  wire       pacing_select       = lp_ctrl_r[`LPRS_PACE_BIT];
  wire       lowpower_recal_on   = lp_ctrl_r[`LPRS_ON_BIT];
  wire       active = lowpower_recal_on && background_recal_on_i;
  // Unselected source is ignored
  wire       recal_trig = trig_src_r ? recal_trigger_input_i : soft_trig_r;

  reg [`LPRS_CNT_W-1:0] idle_len;
  reg [`LPRS_CNT_W-1:0] settle_len;
  always @* begin
    case (idle_interval_sel)
      3'h0:    idle_len = `LPRS_T_1152;
      3'h1:    idle_len = `LPRS_T_4M;
      3'h2:    idle_len = `LPRS_T_33M;
      3'h3:    idle_len = `LPRS_T_268M;
      3'h4:    idle_len = `LPRS_T_2G;
      3'h5:    idle_len = `LPRS_T_17G;
      3'h6:    idle_len = `LPRS_T_137G;
      default: idle_len = `LPRS_T_1T;
    endcase
    case (settle_interval_sel)
      2'h0:    settle_len = `LPRS_T_1152;
      2'h1:    settle_len = `LPRS_T_33M;
      default: settle_len = `LPRS_T_268M;
    endcase
  end

  wire [CNT_W-1:0] idle_last   = idle_len[CNT_W-1:0] - `LPRS_CNT_ONE;
  wire [CNT_W-1:0] settle_last = settle_len[CNT_W-1:0] - `LPRS_CNT_ONE;

  // ****************************************
  // Sleep / settle / calibrate sequencer
  // ****************************************
  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    if (!active) begin
      state_nxt = `LPRS_ST_OFF;
      cnt_nxt   = `LPRS_CNT_ZERO;
    end else begin
      case (state_r)
        `LPRS_ST_OFF: begin
          state_nxt = `LPRS_ST_SLEEP;
          cnt_nxt   = `LPRS_CNT_ZERO;
        end
        `LPRS_ST_SLEEP: begin
          if (pacing_select) begin
            if (!recal_trig) begin
              state_nxt = `LPRS_ST_SETTLE;
              cnt_nxt   = `LPRS_CNT_ZERO;
            end
          end else if (cnt_r >= idle_last) begin
            state_nxt = `LPRS_ST_SETTLE;
            cnt_nxt   = `LPRS_CNT_ZERO;
          end else begin
            cnt_nxt = cnt_r + `LPRS_CNT_ONE;
          end
        end
        `LPRS_ST_SETTLE: begin
          if (cnt_r >= settle_last) begin
            state_nxt = `LPRS_ST_CAL;
            cnt_nxt   = `LPRS_CNT_ZERO;
          end else begin
            cnt_nxt = cnt_r + `LPRS_CNT_ONE;
          end
        end
        `LPRS_ST_CAL: begin
          if (cal_done_i) begin
            state_nxt = `LPRS_ST_SLEEP;
            cnt_nxt   = `LPRS_CNT_ZERO;
          end
        end
        default: begin
          state_nxt = `LPRS_ST_OFF;
          cnt_nxt   = `LPRS_CNT_ZERO;
        end
      endcase
    end
  end

  always @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      state_r      <= `LPRS_ST_OFF;
      cnt_r        <= {CNT_W{1'b0}};
      core_sleep_o <= 1'b0;
      cal_start_o  <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      core_sleep_o <= (state_nxt == `LPRS_ST_SLEEP);
      cal_start_o  <= (state_r == `LPRS_ST_SETTLE) && (state_nxt == `LPRS_ST_CAL);
    end
  end

endmodule // lprs_top

// ===== sim/lprs_top_props.sv
// Port checker for the recalibration scheduler
`timescale 1ns/10ps
`include "lprs_consts.vh"
module lprs_top_props (
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic [8:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       background_recal_on_i,
  input wire logic       core_sleep_o,
  input wire logic       cal_start_o,
  input wire logic [7:0] core_gain_adjust_o,
  input wire logic [3:0] reference_voltage_adjust_o
);
  // ****************************************
  // Cycles since reset release
  // ****************************************
  reg  [2:0] up_cnt_r;
  wire       ready = (up_cnt_r == 3'h7);
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) up_cnt_r <= 3'h0;
    else if (!ready) up_cnt_r <= up_cnt_r + 3'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_quiet8;
    !cal_start_o [*8];
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  a_rdata_idle: assert property (ready && !$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not idle");
  a_gain_hold: assert property (ready && !$past(wr_i) |-> $stable(core_gain_adjust_o))
    else $error("gain trim changed without write");
  a_refv_write: assert property (ready && wr_i && addr_i == `LPRS_OFF_REFV |=>
    {4'h0, reference_voltage_adjust_o} == ($past(wdata_i) & `LPRS_REFV_MASK))
    else $error("reference trim write lost");
  a_gain_read: assert property (ready && rd_i && addr_i == `LPRS_OFF_GAIN |=>
    rdata_o == core_gain_adjust_o) else $error("gain trim read mismatch");
  a_start_pulse: assert property (cal_start_o |=> !cal_start_o)
    else $error("start pulse too long");
  a_start_awake: assert property (cal_start_o |-> !core_sleep_o)
    else $error("start while asleep");
  a_off_awake: assert property (!background_recal_on_i [*3] |-> !core_sleep_o)
    else $error("sleep while background recal off");
  a_settle_gap: assert property ($fell(core_sleep_o) |-> s_quiet8)
    else $error("start too soon after wake");
endmodule // lprs_top_props

bind lprs_top lprs_top_props u_props (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .background_recal_on_i(background_recal_on_i), .core_sleep_o(core_sleep_o),
  .cal_start_o(cal_start_o), .core_gain_adjust_o(core_gain_adjust_o),
  .reference_voltage_adjust_o(reference_voltage_adjust_o));

// ===== sim/test_lowpower_recal_scheduler.sv
// Self-checking bench for the recalibration scheduler
`timescale 1ns/10ps
`include "lprs_consts.vh"
module test_lowpower_recal_scheduler;
  logic       clk_i      = 1'b0;
  logic       resetn_i   = 1'b0;
  logic [8:0] addr_i     = 9'h000;
  logic [7:0] wdata_i    = 8'h00;
  logic       wr_i       = 1'b0;
  logic       rd_i       = 1'b0;
  logic       bg_on      = 1'b0;
  logic       trig       = 1'b0;
  logic       done       = 1'b0;
  wire  [7:0] rdata_o, gain_o, term_o;
  wire  [3:0] refv_o;
  wire        sleep_o, start_o;
  int         n_errors   = 0;
  int         num_checks = 0;
  int         n;
  always #25 clk_i = ~clk_i;
  lprs_top u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .background_recal_on_i(bg_on),
    .recal_trigger_input_i(trig), .fuse_gain_i(8'h5A), .fuse_refv_i(4'h9),
    .fuse_term_a_i(8'hC3), .cal_done_i(done), .core_sleep_o(sleep_o), .cal_start_o(start_o),
    .core_gain_adjust_o(gain_o), .reference_voltage_adjust_o(refv_o),
    .input_termination_adjust_a_o(term_o));
  // ****************************************
  // Tasks
  // ****************************************
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task chk_n(input string what, input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      n_errors++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, got);
    end
  endtask
  task wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [8:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk("rdata", exp, rdata_o);
  endtask
  task wt(input bit s, input logic v);
    n = 0;
    while ((s ? start_o : sleep_o) !== v) begin
      @(negedge clk_i);
      n++;
      if (n > 9000) begin
        n_errors++;
        end_of_test;
      end
    end
  endtask
  task pulse_done;
    @(posedge clk_i);
    done <= 1'b1;
    @(posedge clk_i);
    done <= 1'b0;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(`LPRS_OFF_LP_CTRL, 8'h88);
    chk("term fuse out", 8'hC3, term_o);
    rd(`LPRS_OFF_GAIN, 8'h5A);
    rd(`LPRS_OFF_REFV, 8'h09);
    rd(`LPRS_OFF_TERM_A, 8'hC3);
    rd(9'h100, 8'h00);
    wr(`LPRS_OFF_REFV, 8'hFF);
    rd(`LPRS_OFF_REFV, 8'h0F);
    chk("refv out", 8'h0F, {4'h0, refv_o});
    wr(`LPRS_OFF_GAIN, 8'h3C);
    rd(`LPRS_OFF_GAIN, 8'h3C);
    chk("gain out", 8'h3C, gain_o);
    wr(`LPRS_OFF_TERM_A, 8'h81);
    rd(`LPRS_OFF_TERM_A, 8'h81);
    chk("term out", 8'h81, term_o);
    wr(`LPRS_OFF_LP_CTRL, 8'h01);
    repeat (5) @(posedge clk_i);
    rd(`LPRS_OFF_STATUS, 8'h00);
    $display("test registers done");
    @(posedge clk_i);
    bg_on <= 1'b1;
    wt(0, 1'b1);
    wt(0, 1'b0);
    chk_n("sleep length", 1152, n);
    wt(1, 1'b1);
    chk_n("settle length", 1152, n);
    pulse_done;
    wt(0, 1'b1);
    chk_n("resleep", 1, n <= 3);
    $display("test autonomous done");
    @(posedge clk_i);
    trig <= 1'b1;
    wr(`LPRS_OFF_TRIG_CFG, 8'h01);
    wr(`LPRS_OFF_LP_CTRL, 8'h03);
    repeat (2000) @(negedge clk_i);
    chk("sleep held", 8'h01, {7'h00, sleep_o});
    @(posedge clk_i);
    trig <= 1'b0;
    wt(0, 1'b0);
    chk_n("wake", 1, n <= 3);
    wt(1, 1'b1);
    chk_n("settle paced", 1152, n);
    wr(`LPRS_OFF_TRIG_CFG, 8'h00);
    pulse_done;
    wt(0, 1'b1);
    repeat (1500) @(negedge clk_i);
    chk("soft sleep", 8'h01, {7'h00, sleep_o});
    wr(`LPRS_OFF_SOFT_TRIG, 8'h00);
    wt(0, 1'b0);
    chk_n("soft wake", 1, n <= 4);
    $display("test triggered done");
    @(posedge clk_i);
    bg_on <= 1'b0;
    repeat (4) @(negedge clk_i);
    rd(`LPRS_OFF_STATUS, 8'h00);
    $display("test disable done");
    end_of_test;
  end
endmodule // test_lowpower_recal_scheduler
